// *** hdl/mmc_pkg.sv ***
// Package for the module management control and status block
package mmc_pkg;

    // Clock rate
    localparam int unsigned CLK_HZ         = 100_000_000;

    // Timing figures in their own units
    localparam int unsigned T_INIT_MS      = 2000;
    localparam int unsigned T_RESET_MIN_US = 2;
    localparam int unsigned T_LP_ON_US     = 100;
    localparam int unsigned T_LP_OFF_MS    = 300;
    localparam int unsigned T_INT_ON_MS    = 200;
    localparam int unsigned T_INT_OFF_US   = 500;
    localparam int unsigned T_LOS_MS       = 100;
    localparam int unsigned T_MASK_MS      = 100;
    localparam int unsigned T_RATE_US      = 100;
    localparam int unsigned T_PDN_ON_MS    = 100;
    localparam int unsigned T_PDN_OFF_MS   = 300;

    // Derived cycle counts
    localparam longint unsigned CYC_PER_US = CLK_HZ / 1_000_000;
    localparam longint unsigned CYC_PER_MS = CLK_HZ / 1_000;
    localparam longint unsigned CYC_INIT   = T_INIT_MS * CYC_PER_MS;
    localparam longint unsigned CYC_RSTMIN = T_RESET_MIN_US * CYC_PER_US;
    localparam longint unsigned CYC_LP_ON  = T_LP_ON_US * CYC_PER_US;
    localparam longint unsigned CYC_LP_OFF = T_LP_OFF_MS * CYC_PER_MS;
    localparam longint unsigned CYC_PDN_ON = T_PDN_ON_MS * CYC_PER_MS;
    localparam longint unsigned CYC_RATE   = T_RATE_US * CYC_PER_US;

    // Wishbone register offsets (byte addresses)
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_FLAGS  = 8'h04;
    localparam logic [7:0] REG_MASK   = 8'h08;
    localparam logic [7:0] REG_CTRL   = 8'h0c;

    // Field positions
    localparam int unsigned ST_NOT_READY = 0;
    localparam int unsigned ST_LOW_POWER = 1;
    localparam int unsigned ST_RATE_OK   = 2;
    localparam int unsigned CT_PWR_OVR   = 0;
    localparam int unsigned CT_RATE      = 1;
    localparam int unsigned FL_LOS       = 8;
    localparam int unsigned FL_TXF       = 4;
    localparam int unsigned FL_OTHER     = 0;

    // Reset values
    localparam logic [11:0] MASK_RST = 12'h000;
    localparam logic [1:0]  CTRL_RST = 2'h0;

    // Power sequencing states
    typedef enum logic [1:0] {MMC_INIT, MMC_READY, MMC_LOWPWR, MMC_WAKE} mmc_state_e;

    // Raw condition inputs
    typedef struct packed {
        logic [3:0] rx_los;
        logic [3:0] tx_fault;
        logic [3:0] other;
    } mmc_cond_s;

endpackage : mmc_pkg

// *** hdl/mmc_ctrl.sv ***
// Module management control, status, flags and attention request
//
// Chosen here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// - Fully functional within 2000 ms of power-on or reset release.
// - Reset pin low longer than 2 us is taken as a reset request.
// - Management bus answers within 2000 ms after power-on.
// - Data-not-ready bit clears and attention asserts within 2000 ms.
// - Fully functional means attention asserted due to not-ready clearing.
// - Low-power pin high: power level 1 within 100 us.
// - Low-power pin low: fully functional within 300 ms.
// - Attention output asserts within 200 ms of a triggering condition.
// - Flags clear on read; attention releases within 500 us after.
// - Receive loss of signal sets its flag and attention within 100 ms.
// - Transmit fault sets its flag and attention within 200 ms.
// - Other conditions set their flag and attention within 200 ms.
// - Mask bit set stops its flag asserting attention within 100 ms.
// - Mask bit cleared resumes attention for its flag within 100 ms.
// - Rate-select change brings bandwidth into conformance within 100 us.
// - Power-override set: power level 1 within 100 ms.
// - Power-override cleared: fully functional within 300 ms.
// - Write-triggered latencies are timed from the write's completion.
module mmc_ctrl
    import mmc_pkg::*;
#(
    parameter longint unsigned INIT_CYC   = CYC_INIT,
    parameter longint unsigned LP_OFF_CYC = CYC_LP_OFF,
    parameter longint unsigned RSTMIN_CYC = CYC_RSTMIN
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Sideband pins
    input  wire logic        module_reset_pin_n,
    input  wire logic        low_power_pin,
    output logic             attention_request_n,
    // Conditions from the optics
    input  wire mmc_cond_s   cond_i,
    // Power and rate controls, management-ready status
    output logic             low_power_o,
    output logic             rate_sel_o,
    output logic             mgmt_ready_o
);

    localparam int unsigned CW = 40;

    // Two-flop synchronisers for pins and conditions
    logic [13:0] sync1_r, sync2_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_r <= 14'h2000; // Idle levels: reset pin high, rest low
            sync2_r <= 14'h2000;
        end else begin
            sync1_r <= {module_reset_pin_n, low_power_pin, cond_i};
            sync2_r <= sync1_r;
        end
    end
    wire        rstpin_n_s = sync2_r[13];
    wire        lp_pin_s   = sync2_r[12];
    wire [11:0] cond_s     = sync2_r[11:0];

    // Reset-pin low-time counter; long enough low pulse is a request
    logic [CW-1:0] rlow_cnt_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) rlow_cnt_r <= '0;
        else if (rstpin_n_s) rlow_cnt_r <= '0;
        else if (rlow_cnt_r <= CW'(RSTMIN_CYC)) rlow_cnt_r <= rlow_cnt_r + 1'b1;
    end
    wire pin_reset = rlow_cnt_r > CW'(RSTMIN_CYC);

    // Wishbone decode
    wire wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire hit_st  = wb_adr_i == REG_STATUS;
    wire hit_fl  = wb_adr_i == REG_FLAGS;
    wire hit_mk  = wb_adr_i == REG_MASK;
    wire hit_ct  = wb_adr_i == REG_CTRL;
    wire wr_mk   = wb_req && wb_we_i && hit_mk && mgmt_ready_o;
    wire wr_ct   = wb_req && wb_we_i && hit_ct && mgmt_ready_o && wb_sel_i[0];
    wire rd_fl   = wb_req && !wb_we_i && hit_fl && mgmt_ready_o;

    // Power sequencing state machine
    mmc_state_e    st_r, st_nxt;
    logic [CW-1:0] tmr_r, tmr_nxt;
    logic [1:0]    ctrl_r;
    wire           want_low = lp_pin_s || ctrl_r[CT_PWR_OVR];
    always_comb begin
        st_nxt  = st_r;
        tmr_nxt = tmr_r + 1'b1;
        unique case (st_r)
            MMC_INIT: if (tmr_r >= CW'(INIT_CYC - 1)) begin
                st_nxt  = want_low ? MMC_LOWPWR : MMC_READY;
                tmr_nxt = '0;
            end
            MMC_READY: if (want_low) st_nxt = MMC_LOWPWR;
            MMC_LOWPWR: if (!want_low) begin
                st_nxt  = MMC_WAKE;
                tmr_nxt = '0;
            end
            MMC_WAKE: if (want_low) st_nxt = MMC_LOWPWR;
                else if (tmr_r >= CW'(LP_OFF_CYC - 1)) st_nxt = MMC_READY;
        endcase
        if (pin_reset) begin
            st_nxt  = MMC_INIT;
            tmr_nxt = '0;
        end
    end

    // Not-ready bit: set in init, cleared on leaving it
    logic not_ready_r;
    logic ready_ev;
    assign ready_ev = (st_r == MMC_INIT) && (st_nxt != MMC_INIT);

    // Flags: sticky, set wins over clear-on-read
    logic [11:0] flags_r, mask_r;
    logic        nr_flag_r;
    wire  [11:0] flags_nxt = (rd_fl ? 12'h000 : flags_r) | cond_s;
    wire         any_unmasked = |(flags_r & ~mask_r) || nr_flag_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r        <= MMC_INIT;
            tmr_r       <= '0;
            not_ready_r <= 1'b1;
            nr_flag_r   <= 1'b0;
            flags_r     <= 12'h000;
        end else begin
            st_r        <= st_nxt;
            tmr_r       <= (st_nxt == MMC_INIT || st_nxt == MMC_WAKE) ? tmr_nxt : '0;
            not_ready_r <= pin_reset ? 1'b1 : (ready_ev ? 1'b0 : not_ready_r);
            nr_flag_r   <= pin_reset ? 1'b0 : (ready_ev ? 1'b1 : (rd_fl ? 1'b0 : nr_flag_r));
            flags_r     <= pin_reset ? 12'h000 : flags_nxt;
        end
    end

    // Control registers, written at the completing edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_r <= MASK_RST;
            ctrl_r <= CTRL_RST;
        end else if (pin_reset) begin
            mask_r <= MASK_RST;
            ctrl_r <= CTRL_RST;
        end else begin
            if (wr_mk && wb_sel_i[0]) mask_r[7:0]  <= wb_dat_i[7:0];
            if (wr_mk && wb_sel_i[1]) mask_r[11:8] <= wb_dat_i[11:8];
            if (wr_ct) ctrl_r <= wb_dat_i[1:0];
        end
    end

    // Read mux
    wire [31:0] rd_val = hit_st ? {29'h0, rate_sel_o, low_power_o, not_ready_r} :
                         hit_fl ? {19'h0, nr_flag_r, flags_r} :
                         hit_mk ? {20'h0, mask_r} :
                         hit_ct ? {30'h0, ctrl_r} : 32'h0;

    // Bus answer and registered outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_ack_o            <= 1'b0;
            wb_dat_o            <= 32'h0;
            attention_request_n <= 1'b1;
            low_power_o         <= 1'b0;
            rate_sel_o          <= 1'b0;
            mgmt_ready_o        <= 1'b0;
        end else begin
            wb_ack_o            <= wb_req;
            wb_dat_o            <= wb_req && !wb_we_i ? rd_val : 32'h0;
            attention_request_n <= !any_unmasked;
            low_power_o         <= st_r == MMC_LOWPWR || st_r == MMC_INIT;
            rate_sel_o          <= ctrl_r[CT_RATE];
            mgmt_ready_o        <= st_r != MMC_INIT;
        end
    end

    // Assertions
    AST_ATTN_FOLLOWS: assert property (@(posedge clk) disable iff (rst)
        |(flags_r & ~mask_r) |=> !attention_request_n)
        else $error("attention not asserted with unmasked flag");
    AST_READ_CLEARS: assert property (@(posedge clk) disable iff (rst)
        rd_fl && !pin_reset |=> (flags_r & ~$past(cond_s)) == 12'h000)
        else $error("flags not cleared by read");
    AST_COND_SETS: assert property (@(posedge clk) disable iff (rst)
        cond_s[FL_LOS] && !pin_reset |=> flags_r[FL_LOS])
        else $error("loss flag not set");
    AST_TXF_SETS: assert property (@(posedge clk) disable iff (rst)
        cond_s[FL_TXF] && !pin_reset |=> flags_r[FL_TXF] ##1 !attention_request_n || mask_r[FL_TXF])
        else $error("fault flag not set");
    AST_MASKED_QUIET: assert property (@(posedge clk) disable iff (rst)
        (mask_r == 12'hfff) && !nr_flag_r ##1 (mask_r == 12'hfff) && !nr_flag_r
        |-> attention_request_n)
        else $error("masked flags drive attention");
    AST_LOWPWR: assert property (@(posedge clk) disable iff (rst)
        st_r == MMC_READY && want_low && !pin_reset |=> st_r == MMC_LOWPWR ##1 low_power_o)
        else $error("low power not entered");
    AST_RESET_REQ: assert property (@(posedge clk) disable iff (rst)
        pin_reset |=> st_r == MMC_INIT && not_ready_r)
        else $error("reset request ignored");
    AST_READY_FLAG: assert property (@(posedge clk) disable iff (rst)
        ready_ev && !pin_reset |=> !not_ready_r && nr_flag_r ##1 !attention_request_n)
        else $error("ready event missing attention");
    AST_RATE: assert property (@(posedge clk) disable iff (rst)
        wr_ct && !pin_reset |=> ##1 rate_sel_o == $past(wb_dat_i[CT_RATE], 2))
        else $error("rate select not applied");
    AST_ACK_ONE: assert property (@(posedge clk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

endmodule : mmc_ctrl

// *** tb/mmc_optics_model.sv ***
// Optics side model driving loss, fault and other condition levels
`timescale 1ns/1ps
module mmc_optics_model
    import mmc_pkg::*;
(
    // Clock
    input  wire logic       clk,
    // Request: 0 none, 1 loss, 2 fault, 3 other
    input  wire logic [1:0] kind,
    input  wire logic [3:0] lanes,
    // Levels towards the block
    output mmc_cond_s       cond
);
    // Quiet optics at time zero
    initial cond = '0;
    // Levels change just after an edge, one kind at a time
    always @(posedge clk) begin
        cond.rx_los   <= (kind == 2'h1) ? lanes : 4'h0;
        cond.tx_fault <= (kind == 2'h2) ? lanes : 4'h0;
        cond.other    <= (kind == 2'h3) ? lanes : 4'h0;
    end
endmodule : mmc_optics_model

// *** tb/tb_mmc_ctrl.sv ***
// Bench for the management control block over Wishbone and sideband pins
`timescale 1ns/1ps
module tb_mmc_ctrl
    import mmc_pkg::*;
;
    localparam longint unsigned INIT = 100;
    localparam longint unsigned LPOFF = 50;
    localparam longint unsigned RMIN = 20;
    logic        clk, rst, cyc, stb, we, rpin_n, lp, ack, att_n, lpo, rate, ready;
    logic [7:0]  adr;
    logic [3:0]  sel, lanes;
    logic [31:0] wdat, dat_o, rd;
    logic [1:0]  kind;
    logic [11:0] fl;
    mmc_cond_s   cond;
    int          failures, compares, cycles, k;
    // Design and optics model
    mmc_ctrl #(.INIT_CYC(INIT), .LP_OFF_CYC(LPOFF), .RSTMIN_CYC(RMIN)) u_dut (
        .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .module_reset_pin_n(rpin_n), .low_power_pin(lp),
        .attention_request_n(att_n), .cond_i(cond), .low_power_o(lpo),
        .rate_sel_o(rate), .mgmt_ready_o(ready));
    mmc_optics_model u_optics (.clk(clk), .kind(kind), .lanes(lanes), .cond(cond));
    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Verdict and end of run
    task automatic close_out();
        $display("counts: %0d compares, %0d failures", compares, failures);
        if (failures == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    // Compare and report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One classic cycle; data taken at the ack edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb
    // Bounded wait for an output level, then compare
    task automatic await(input int id, input logic v, input longint unsigned lim);
        logic s;
        for (longint unsigned n = 0; n <= lim; n++) begin
            s = (id == 0) ? att_n : (id == 1) ? lpo : ready;
            if (s === v) break;
            @(posedge clk);
        end
        chk({31'h0, s}, {31'h0, v});
    endtask : await
    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            close_out();
        end
    end
    initial begin
        {rst, cyc, stb, we, lp, kind, failures, compares, cycles} = '0;
        {adr, wdat, lanes} = '0;
        rst = 1'b1;
        rpin_n = 1'b1;
        sel = 4'hf;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk({31'h0, lpo}, 32'h1);
        await(2, 1'b1, INIT + 10);
        await(0, 1'b0, 8);
        wb(1'b0, REG_STATUS, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, REG_FLAGS, 32'h0);
        chk(rd, 32'h1000);
        await(0, 1'b1, 8);
        $display("init test done");
        for (k = 1; k <= 3; k++) begin
            fl = 12'h1 << (12 - 4 * k + k - 1);
            kind <= k[1:0];
            lanes <= 4'h1 << (k - 1);
            await(0, 1'b0, 8);
            kind <= 2'h0;
            repeat (6) @(posedge clk);
            chk({31'h0, att_n}, 32'h0);
            wb(1'b0, REG_FLAGS, 32'h0);
            chk(rd, {20'h0, fl});
            await(0, 1'b1, 8);
        end
        $display("flag test done");
        wb(1'b1, REG_MASK, 32'hfff);
        kind <= 2'h1;
        lanes <= 4'h1;
        repeat (10) @(posedge clk);
        chk({31'h0, att_n}, 32'h1);
        wb(1'b1, REG_MASK, 32'h0);
        await(0, 1'b0, 8);
        kind <= 2'h0;
        repeat (6) @(posedge clk);
        wb(1'b0, REG_FLAGS, 32'h0);
        chk(rd, 32'h100);
        $display("mask test done");
        wb(1'b1, REG_CTRL, 32'h2);
        repeat (3) @(posedge clk);
        chk({31'h0, rate}, 32'h1);
        wb(1'b1, REG_CTRL, 32'h3);
        await(1, 1'b1, 8);
        wb(1'b0, REG_STATUS, 32'h0);
        chk(rd, 32'h6);
        wb(1'b1, REG_CTRL, 32'h2);
        await(1, 1'b0, LPOFF + 10);
        lp <= 1'b1;
        await(1, 1'b1, 8);
        lp <= 1'b0;
        await(1, 1'b0, LPOFF + 10);
        $display("power test done");
        wb(1'b1, 8'h40, 32'hffff_ffff);
        wb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        rpin_n <= 1'b0;
        repeat (10) @(posedge clk);
        rpin_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk({31'h0, ready}, 32'h1);
        rpin_n <= 1'b0;
        repeat (RMIN + 6) @(posedge clk);
        rpin_n <= 1'b1;
        await(2, 1'b0, 8);
        wb(1'b0, REG_STATUS, 32'h0);
        chk(rd & 32'h5, 32'h1);
        await(2, 1'b1, INIT + 10);
        $display("reset pin test done");
        close_out();
    end
endmodule : tb_mmc_ctrl
